// File: rtl/bus_port_pkg.sv
// Purpose: shared constants for the serial bus port configuration block
// Assumes: pclk at 10 MHz, APB with 32-bit data
// Notes:   offsets are register indices; the APB byte address is four
//          times the index
package bus_port_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0]  CFG_OFFSET    = 8'hc1;
  localparam logic [7:0]  STATUS_OFFSET = 8'hc2;
  localparam logic [7:0]  MASK_OFFSET   = 8'hc3;
  // one aligned 32-bit word per register index
  localparam logic [11:0] CFG_ADDR      = {2'b00, CFG_OFFSET, 2'b00};
  localparam logic [11:0] STATUS_ADDR   = {2'b00, STATUS_OFFSET, 2'b00};
  localparam logic [11:0] MASK_ADDR     = {2'b00, MASK_OFFSET, 2'b00};
  localparam logic [7:0] CFG_RESET     = 8'h00;
  localparam logic [7:0] STATUS_RESET  = 8'h00;
  localparam logic [7:0] MASK_RESET    = 8'h00;

  // ----------------------------------------------------------------------
  // configuration field positions
  // ----------------------------------------------------------------------
  localparam int ENABLE_POS   = 7;
  localparam int INHIBIT_POS  = 6;
  localparam int BUSY_POS     = 5;
  localparam int EXTHOLD_POS  = 4;
  localparam int TOE_POS      = 3;
  localparam int FTE_POS      = 2;
  localparam int CS_HI_POS    = 1;
  localparam int CS_LO_POS    = 0;

  // status bit positions
  localparam int EV_START_POS = 0;
  localparam int EV_STOP_POS  = 1;
  localparam int EV_FREE_POS  = 2;
  localparam int EV_SLAVE_POS = 3;
  localparam int EV_MAST_POS  = 4;

  // ----------------------------------------------------------------------
  // clock source codes
  // ----------------------------------------------------------------------
  localparam logic [1:0] CS_TIMER0    = 2'h0;
  localparam logic [1:0] CS_TIMER1    = 2'h1;
  localparam logic [1:0] CS_TIMER2_HI = 2'h2;
  localparam logic [1:0] CS_TIMER2_LO = 2'h3;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int FREE_PERIODS   = 10;
  localparam int PHASE_PERIODS  = 1;
  localparam int SETUP_EXT_CLKS = 11;
  localparam int HOLD_EXT_CLKS  = 12;
  localparam int HOLD_STD_CLKS  = 3;

endpackage : bus_port_pkg

// File: rtl/line_sync.sv
// Purpose: two-flop synchroniser for a single pin level
// Assumes: input is asynchronous to pclk
// Notes:   first stage is read only by the second stage
module line_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic din,
  output logic      dout
);

  logic meta;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule : line_sync

// File: rtl/sda_delay.sv
// Purpose: holds the outgoing data level stable for a timed window
// Assumes: request strobes arrive on pclk
// Notes:   new level launches after the hold count from the clock fall
module sda_delay (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       scl_fall,
  input  wire logic       data_in,
  input  wire logic [3:0] hold_clks,
  output logic            data_out
);

  logic [3:0] cnt;

  // data may only change once the hold window after a clock fall ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt      <= 4'h0;
      data_out <= 1'b1;
    end else if (scl_fall) begin
      cnt <= hold_clks;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else begin
      data_out <= data_in;
    end
  end

endmodule : sda_delay

// File: rtl/bus_port_config.sv
// Purpose: configuration, busy tracking and timeout supervision of port 0
// Assumes: APB slave on pclk, bus pins asynchronous, timers outside
// Notes:   byte engine lives elsewhere; this block gives it timing help
//
// Behaviour
// - enable bit makes port watch both lines
// - inhibit bit suppresses slave event interrupts
// - busy flag set while transfer runs
// - busy cleared on stop or free timeout
// - hold extension bit picks data timing
// - extended 11 setup, 12 hold; else 3
// - timeout enable reloads timer while clock high
// - split timer reloads only upper byte
// - free after ten source periods both high
// - two-bit field picks overflow clock source
// - code 00 timer 0, 11 timer2 low
// - code 01 timer 1, 10 timer2 high
// - master phases last one overflow period
//
// The APB register port was decided locally.
module bus_port_config
  import bus_port_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        port_clock_line_in,
  input  wire logic        port_data_line_in,
  input  wire logic        timer0_ovf,
  input  wire logic        timer1_ovf,
  input  wire logic        timer2_hi_ovf,
  input  wire logic        timer2_lo_ovf,
  input  wire logic        sup_timer_split,
  input  wire logic        slave_event,
  input  wire logic        master_event,
  input  wire logic        engine_data,
  output logic             engine_data_out,
  output logic             sup_reload_full,
  output logic             sup_reload_high,
  output logic             phase_ok,
  output logic             port_irq,
  output logic             port_active
);

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [7:0] cfg;
  logic       transfer_busy_flag;
  logic [4:0] status;
  logic [4:0] mask;

  logic port_enable_bit;
  logic slave_inhibit_bit;
  logic hold_extension_bit;
  logic clock_low_timeout_enable;
  logic bus_free_timeout_enable;
  logic [1:0] clock_source_select;

  assign port_enable_bit          = cfg[ENABLE_POS];
  assign slave_inhibit_bit        = cfg[INHIBIT_POS];
  assign hold_extension_bit       = cfg[EXTHOLD_POS];
  assign clock_low_timeout_enable = cfg[TOE_POS];
  assign bus_free_timeout_enable  = cfg[FTE_POS];
  assign clock_source_select      = cfg[CS_HI_POS:CS_LO_POS];

  // ----------------------------------------------------------------------
  // pin synchronisers and line events
  // ----------------------------------------------------------------------
  logic scl_s;
  logic sda_s;
  logic scl_q;
  logic sda_q;

  line_sync u_scl_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (port_clock_line_in),
    .dout    (scl_s)
  );

  line_sync u_sda_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (port_data_line_in),
    .dout    (sda_s)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  logic start_det;
  logic stop_det;
  logic scl_fall;
  logic scl_rise;

  // lines are watched only while enabled
  assign start_det = port_enable_bit && scl_s && sda_q && !sda_s;
  assign stop_det  = port_enable_bit && scl_s && !sda_q && sda_s;
  assign scl_fall  = port_enable_bit && scl_q && !scl_s;
  assign scl_rise  = port_enable_bit && !scl_q && scl_s;

  // ----------------------------------------------------------------------
  // clock source selection
  // ----------------------------------------------------------------------
  function automatic logic pick_source(input logic [1:0] sel,
                                       input logic t0,
                                       input logic t1,
                                       input logic t2h,
                                       input logic t2l);
    logic r;
    r = 1'b0;
    unique case (sel)
      CS_TIMER0:    r = t0;
      CS_TIMER1:    r = t1;
      CS_TIMER2_HI: r = t2h;
      CS_TIMER2_LO: r = t2l;
    endcase
    return r;
  endfunction : pick_source

  logic ovf_tick;
  assign ovf_tick = pick_source(clock_source_select, timer0_ovf,
                                timer1_ovf, timer2_hi_ovf,
                                timer2_lo_ovf);

  // ----------------------------------------------------------------------
  // bus free detection
  // ----------------------------------------------------------------------
  logic [3:0] free_cnt;
  logic       free_tmo;

  // counts whole source periods with both lines high; any low restarts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      free_cnt <= 4'h0;
    end else if (!(scl_s && sda_s) || !bus_free_timeout_enable ||
                 !port_enable_bit) begin
      free_cnt <= 4'h0;
    end else if (ovf_tick && free_cnt <= 4'(FREE_PERIODS)) begin
      free_cnt <= free_cnt + 4'h1;
    end
  end

  // more than ten periods: the eleventh tick qualifies
  assign free_tmo = ovf_tick && scl_s && sda_s && port_enable_bit &&
                    bus_free_timeout_enable &&
                    free_cnt == 4'(FREE_PERIODS);

  // ----------------------------------------------------------------------
  // busy flag
  // ----------------------------------------------------------------------
  // line activity sets and clears it; a bus write clears it only by clearing the enable bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transfer_busy_flag <= 1'b0;
    end else if (!port_enable_bit) begin
      transfer_busy_flag <= 1'b0;
    end else if (start_det) begin
      transfer_busy_flag <= 1'b1;
    end else if (stop_det || free_tmo) begin
      transfer_busy_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // slave inhibit takes effect at once while idle, else at the next start or once busy clears
  // ----------------------------------------------------------------------
  logic inhibit_live;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inhibit_live <= 1'b0;
    end else if (start_det || !transfer_busy_flag) begin
      inhibit_live <= slave_inhibit_bit;
    end
  end

  // ----------------------------------------------------------------------
  // clock-low supervision
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sup_reload_full <= 1'b0;
      sup_reload_high <= 1'b0;
    end else begin
      // split timer: only its upper byte is held while clock is high
      sup_reload_full <= clock_low_timeout_enable && port_enable_bit &&
                         scl_s && !sup_timer_split;
      sup_reload_high <= clock_low_timeout_enable && port_enable_bit &&
                         scl_s && sup_timer_split;
    end
  end
  // timer programming at 25 ms is the software's job

  // ----------------------------------------------------------------------
  // master phase timing: a phase may end after one overflow
  // ----------------------------------------------------------------------
  logic [1:0] phase_cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_cnt <= 2'h0;
      phase_ok  <= 1'b0;
    end else if (scl_fall || scl_rise) begin
      phase_cnt <= 2'h0;
      phase_ok  <= 1'b0;
    end else if (ovf_tick && phase_cnt < 2'(PHASE_PERIODS)) begin
      phase_cnt <= phase_cnt + 2'h1;
      phase_ok  <= (phase_cnt + 2'h1) >= 2'(PHASE_PERIODS);
    end
  end

  // ----------------------------------------------------------------------
  // data line hold window
  // ----------------------------------------------------------------------
  // setup of 11 is met since hold plus launch precede the next rise
  logic [3:0] hold_clks;
  assign hold_clks = hold_extension_bit ? 4'(HOLD_EXT_CLKS)
                                        : 4'(HOLD_STD_CLKS);

  logic held_data;

  sda_delay u_sda_delay (
    .pclk      (pclk),
    .presetn   (presetn),
    .scl_fall  (scl_fall),
    .data_in   (engine_data),
    .hold_clks (hold_clks),
    .data_out  (held_data)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      engine_data_out <= 1'b1;
      port_active     <= 1'b0;
    end else begin
      engine_data_out <= held_data;
      port_active     <= port_enable_bit;
    end
  end

  // ----------------------------------------------------------------------
  // event status, mask and interrupt
  // ----------------------------------------------------------------------
  logic       wr_en;
  logic       rd_en;
  logic [4:0] ev_set;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  always_comb begin
    ev_set = 5'h0;
    ev_set[EV_START_POS] = start_det;
    ev_set[EV_STOP_POS]  = stop_det;
    ev_set[EV_FREE_POS]  = free_tmo;
    ev_set[EV_SLAVE_POS] = slave_event && port_enable_bit &&
                           !inhibit_live;
    ev_set[EV_MAST_POS]  = master_event && port_enable_bit;
  end

  // a read clears only the bits it reported, so an event landing
  // between the answer and the access edge is not lost; an event in
  // the same cycle as the clear wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= STATUS_RESET[4:0];
    end else if (rd_en && paddr == STATUS_ADDR) begin
      status <= (status & ~prdata[4:0]) | ev_set;
    end else begin
      status <= status | ev_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_irq <= 1'b0;
    end else begin
      port_irq <= |(status & mask);
    end
  end

  // ----------------------------------------------------------------------
  // APB register access
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg  <= CFG_RESET;
      mask <= MASK_RESET[4:0];
    end else if (wr_en && paddr == CFG_ADDR) begin
      cfg <= {pwdata[7:6], 1'b0, pwdata[4:0]};
    end else if (wr_en && paddr == MASK_ADDR) begin
      mask <= pwdata[4:0];
    end
  end

  // the setup cycle is answered at once: no wait states, so a master
  // that holds its request for the access phase always completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !pready;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      if (psel && !pready) begin
        unique case (paddr)
          CFG_ADDR: begin
            prdata <= {24'h0, cfg[7:6], transfer_busy_flag, cfg[4:0]};
          end
          STATUS_ADDR: begin
            prdata <= {27'h0, status};
          end
          MASK_ADDR: begin
            prdata <= {27'h0, mask};
          end
          default: begin
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule : bus_port_config

// File: dv/port_checker.sv
// Purpose: port assertions for the bus port configuration block
// Assumes: single pclk domain
// Notes:   config and mask are shadowed from completed APB writes
module port_checker
  import bus_port_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        port_clock_line_in,
  input wire logic        timer0_ovf,
  input wire logic        timer1_ovf,
  input wire logic        timer2_hi_ovf,
  input wire logic        timer2_lo_ovf,
  input wire logic        sup_timer_split,
  input wire logic        master_event,
  input wire logic        engine_data_out,
  input wire logic        sup_reload_full,
  input wire logic        sup_reload_high,
  input wire logic        phase_ok,
  input wire logic        port_irq,
  input wire logic        port_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] cfg_sh;
  logic [7:0] msk_sh;
  logic [3:0] still;
  logic [3:0] ovfs;
  logic       wr_done;
  assign wr_done = psel && penable && pready && pwrite;
  assign ovfs    = {timer2_lo_ovf, timer2_hi_ovf, timer1_ovf, timer0_ovf};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_sh <= 8'h00;
      msk_sh <= 8'h00;
    end else if (wr_done && paddr == CFG_ADDR) begin
      cfg_sh <= pwdata[7:0];
    end else if (wr_done && paddr == MASK_ADDR) begin
      msk_sh <= pwdata[7:0];
    end
  end
  // age of the clock pin level; the synchroniser lags it by a few cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      still <= 4'h0;
    end else if ($changed(port_clock_line_in)) begin
      still <= 4'h0;
    end else if (still != 4'hf) begin
      still <= still + 4'h1;
    end
  end
  property p_answer;
    psel && !penable && !pready |=> pready;
  endproperty
  a_answer: assert property (p_answer)
    else $error("no answer in access cycle");
  property p_active;
    wr_done && paddr == CFG_ADDR |=> ##[0:1] port_active == cfg_sh[7];
  endproperty
  a_active: assert property (p_active)
    else $error("active flag does not follow enable");
  property p_low;
    (!port_clock_line_in)[*5] |-> !sup_reload_full && !sup_reload_high;
  endproperty
  a_low: assert property (p_low)
    else $error("reload while clock line low");
  property p_full;
    (port_clock_line_in && cfg_sh[7] && cfg_sh[3] && !sup_timer_split)[*5]
      |-> sup_reload_full && !sup_reload_high;
  endproperty
  a_full: assert property (p_full)
    else $error("whole timer not held in reload");
  property p_high;
    (port_clock_line_in && cfg_sh[7] && cfg_sh[3] && sup_timer_split)[*5]
      |-> sup_reload_high && !sup_reload_full;
  endproperty
  a_high: assert property (p_high)
    else $error("split timer reload wrong");
  property p_mast;
    master_event && msk_sh[EV_MAST_POS] && port_active |-> ##[1:3] port_irq;
  endproperty
  a_mast: assert property (p_mast)
    else $error("master event raised no interrupt");
  property p_phase;
    still > 4'h5 && ovfs[cfg_sh[1:0]] && port_active |-> ##[1:2] phase_ok;
  endproperty
  a_phase: assert property (p_phase)
    else $error("selected overflow not seen");
  property p_hold;
    $fell(port_clock_line_in) |=> $stable(engine_data_out)[*2];
  endproperty
  a_hold: assert property (p_hold)
    else $error("data changed inside hold window");
  c_irq: cover property (port_irq);
  c_high: cover property (sup_reload_high);
  c_phase: cover property (phase_ok);
endmodule : port_checker

bind bus_port_config port_checker u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .port_clock_line_in, .timer0_ovf, .timer1_ovf, .timer2_hi_ovf,
  .timer2_lo_ovf, .sup_timer_split, .master_event, .engine_data_out,
  .sup_reload_full, .sup_reload_high, .phase_ok, .port_irq, .port_active
);

// File: dv/bus_peer.sv
// Purpose: another master driving both bus lines
// Assumes: lines have pull-ups, so released means high
// Notes:   link clock runs only inside frames, off the pclk grid
module bus_peer (
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 400;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // start then eight bits; leaves the clock low, the bus still owned
  task automatic frame(input logic [7:0] b);
    #37 sda = 1'b0;
    #HALF scl = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #(HALF/2) sda = b[i];
      #(HALF/2) scl = 1'b1;
      #HALF scl = 1'b0;
    end
    #(HALF/2) sda = 1'b0;
  endtask : frame
  task automatic stop();
    #(HALF/2) scl = 1'b1;
    #HALF sda = 1'b1;
  endtask : stop
  // abort: data rises while clock low, so no stop is seen
  task automatic release_lines();
    #(HALF/2) sda = 1'b1;
    #(HALF/2) scl = 1'b1;
  endtask : release_lines
  task automatic set(input logic s, input logic d);
    #37 scl = s;
    sda = d;
  endtask : set
endmodule : bus_peer

// File: dv/testbench.sv
// Purpose: self-checking bench for the bus port configuration block
// Assumes: pclk 100 ns, peer model drives the bus lines
// Notes:   expectations come from the cfg_read bench function and literal values
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import bus_port_pkg::*;
  logic        pclk;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [3:0]  ovf     = 4'h0;
  logic        split   = 1'b0;
  logic        sev     = 1'b0;
  logic        mev     = 1'b0;
  logic        edata   = 1'b1;
  logic [31:0] prdata, rdq;
  logic        pready, pslverr, rde, edata_out, rfull, rhigh, irq, act, pok;
  logic        scl, sda;
  logic [7:0]  d;
  int          n_fail = 0;
  int          comparisons = 0;
  logic [11:0] addrs [3] = '{CFG_ADDR, STATUS_ADDR, MASK_ADDR};

  bus_peer peer (.scl(scl), .sda(sda));
  bus_port_config dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_clock_line_in(scl),
    .port_data_line_in(sda), .timer0_ovf(ovf[0]), .timer1_ovf(ovf[1]),
    .timer2_hi_ovf(ovf[2]), .timer2_lo_ovf(ovf[3]),
    .sup_timer_split(split), .slave_event(sev), .master_event(mev),
    .engine_data(edata), .engine_data_out(edata_out),
    .sup_reload_full(rfull), .sup_reload_high(rhigh), .phase_ok(pok),
    .port_irq(irq), .port_active(act));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] cfg_read(input logic [7:0] w,
                                           input logic busy);
    return {24'h0, w[7:6], busy, w[4:0]};
  endfunction : cfg_read
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [7:0] w);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= {24'h0, w};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      end_sim();
    end
    rdq = prdata;
    rde = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wt(input int k);
    repeat (k) @(posedge pclk);
  endtask : wt
  task automatic pulse(input logic [3:0] m, input int k);
    repeat (k) begin
      @(posedge pclk);
      ovf <= m;
      @(posedge pclk);
      ovf <= 4'h0;
    end
  endtask : pulse
  task automatic ev(input logic s, input logic m);
    @(posedge pclk);
    sev <= s;
    mev <= m;
    @(posedge pclk);
    sev <= 1'b0;
    mev <= 1'b0;
  endtask : ev

  initial begin
    repeat (60000) @(posedge pclk);
    n_fail++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(87337));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (addrs[i]) begin
      apb(1'b0, addrs[i], 8'h00);
      check(rdq, 32'h0);
      check(32'(rde), 32'h0);
    end
    apb(1'b0, 12'h010, 8'h00);
    check(32'(rde), 32'h1);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom) | 8'h20;
      apb(1'b1, CFG_ADDR, d);
      apb(1'b0, CFG_ADDR, 8'h00);
      check(rdq, cfg_read(d, 1'b0));
      check(32'(act), 32'(d[7]));
    end
    $display("test config done");
    apb(1'b1, CFG_ADDR, 8'h80);
    peer.frame(8'($urandom));
    apb(1'b0, CFG_ADDR, 8'h00);
    check(rdq, cfg_read(8'h80, 1'b1));
    peer.stop();
    wt(5);
    apb(1'b0, CFG_ADDR, 8'h00);
    check(rdq, cfg_read(8'h80, 1'b0));
    apb(1'b0, STATUS_ADDR, 8'h00);
    check(32'(rdq[1:0]), 32'h3);
    $display("test busy done");
    for (int cs = 0; cs < 4; cs++) begin
      d = 8'h84 | 8'(cs);
      apb(1'b1, CFG_ADDR, d);
      peer.frame(8'($urandom));
      peer.release_lines();
      wt(5);
      pulse(~(4'h1 << cs), 12);
      apb(1'b0, CFG_ADDR, 8'h00);
      check(rdq, cfg_read(d, 1'b1));
      check(32'(pok), 32'h0);
      pulse(4'h1 << cs, 10);
      apb(1'b0, CFG_ADDR, 8'h00);
      check(rdq, cfg_read(d, 1'b1));
      check(32'(pok), 32'h1);
      pulse(4'h1 << cs, 1);
      wt(4);
      apb(1'b0, CFG_ADDR, 8'h00);
      check(rdq, cfg_read(d, 1'b0));
      apb(1'b0, STATUS_ADDR, 8'h00);
      check(32'(rdq[EV_FREE_POS]), 32'h1);
    end
    $display("test free timeout done");
    apb(1'b1, MASK_ADDR, 8'h18);
    apb(1'b1, CFG_ADDR, 8'hc0);
    ev(1'b1, 1'b0);
    wt(3);
    check(32'(irq), 32'h0);
    ev(1'b0, 1'b1);
    wt(3);
    check(32'(irq), 32'h1);
    apb(1'b0, STATUS_ADDR, 8'h00);
    wt(2);
    check(32'(irq), 32'h0);
    apb(1'b1, CFG_ADDR, 8'h80);
    ev(1'b1, 1'b0);
    wt(3);
    check(32'(irq), 32'h1);
    apb(1'b1, MASK_ADDR, 8'h00);
    apb(1'b0, STATUS_ADDR, 8'h00);
    ev(1'b0, 1'b1);
    wt(3);
    check(32'(irq), 32'h0);
    apb(1'b0, STATUS_ADDR, 8'h00);
    check(32'(rdq[EV_MAST_POS]), 32'h1);
    $display("test interrupt done");
    apb(1'b1, CFG_ADDR, 8'h88);
    wt(6);
    check(32'({rfull, rhigh}), 32'h2);
    split <= 1'b1;
    wt(6);
    check(32'({rfull, rhigh}), 32'h1);
    peer.frame(8'($urandom));
    wt(6);
    check(32'({rfull, rhigh}), 32'h0);
    apb(1'b0, CFG_ADDR, 8'h00);
    check(rdq, cfg_read(8'h88, 1'b1));
    // timer handler: clock held low too long, port disabled and re-enabled
    apb(1'b1, CFG_ADDR, 8'h08);
    apb(1'b1, CFG_ADDR, 8'h88);
    apb(1'b0, CFG_ADDR, 8'h00);
    check(rdq, cfg_read(8'h88, 1'b0));
    peer.release_lines();
    $display("test reload done");
    for (int eh = 0; eh < 2; eh++) begin
      apb(1'b1, CFG_ADDR, 8'h80 | 8'(eh << 4));
      peer.set(1'b0, 1'b1);
      // new engine level only once the synchronised clock fall is seen
      wt(2);
      edata <= ~edata;
      wt(10);
      check(32'(edata_out), 32'(eh ? !edata : edata));
      wt(20);
      check(32'(edata_out), 32'(edata));
      peer.set(1'b1, 1'b1);
    end
    $display("test hold done");
    end_sim();
  end
endmodule : testbench
